/* File: core_irq_model.sv */
// Core and interrupt flag model facing the vector locator
`default_nettype none
module core_irq_model
(
    input  wire logic        clk,
    input  wire logic        en,
    input  wire logic [24:0] post,
    input  wire logic        jv,
    input  wire logic        jr,
    input  wire logic [4:0]  js,
    output logic [24:0]      pending,
    output logic             accept
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy = 1'b0;  // A take awaits its answer
    initial pending = '0;
    initial accept = 1'b0;
    // Flags latch posts and drop when their vector is answered
    always @(posedge clk)
    begin
        // A take is in flight from the accepted edge until the answer
        if (jv)
            busy <= 1'b0;
        else if (accept && |pending)
            busy <= 1'b1;
        // Slots of sources never posted are never fetched
        pending <= (pending | post) & ~((jv && !jr) ? 25'h1 << js : 25'h0);
        // Vectors fetched only while enabled
        accept <= en && (jv || !busy) && !(accept && |pending);
    end
endmodule : core_irq_model
`default_nettype wire

/* File: priority_pick.sv */
// Lowest-index request picker
`include "vector_locator_cfg.svh"
`default_nettype none
module priority_pick #(
    parameter int N = `NUM_SRC,
    parameter int W = 5
) (
    input  wire logic [N-1:0] req,
    output logic              any,
    output logic [W-1:0]      index
);
    // Scan from the top so the lowest set bit is written last
    always_comb
    begin
        any   = 1'b0;
        index = '0;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (req[i])
            begin
                any   = 1'b1;
                index = W'(i);
            end
        end
    end
endmodule : priority_pick
`default_nettype wire

/* File: reset_irq_vector_locator.sv */
// Reset and interrupt vector address generator
`include "vector_locator_cfg.svh"
`default_nettype none
module reset_irq_vector_locator #(
    parameter int                         NSRC      = `NUM_SRC,
    parameter logic [`ADDR_W-1:0]         BOOT_ADDR = `BOOT_RESET
) (
    input  wire logic                     CLK,
    input  wire logic                     RESET,
    input  wire logic                     BOOT_RESET_FUSE,
    input  wire logic                     VECTOR_TABLE_SELECT_BIT,
    input  wire logic [NSRC-1:0]          IRQ_PENDING,
    input  wire logic                     IRQ_ACCEPT,
    output logic                          JUMP_VALID,
    output logic [`ADDR_W-1:0]            JUMP_ADDR,
    output logic                          JUMP_IS_RESET,
    output logic [4:0]                    JUMP_SOURCE
);
    import vector_locator_pkg::*;

    // How a jump is formed:
    // after every reset release the sequencer forms the reset entry once;
    // from then on each accept with a source pending becomes one jump,
    // two edges after the accept; the target is worked out at issue time
    // from the fuse, the select bit and the lowest pending source.
    // The core must not accept again until it has seen the strobe;
    // an accept in the cycle after a take is simply not looked at.

    // Sequencer state; the reset entry goes out once per release
    jump_state_t          state;           // Current phase
    jump_state_t          next_state;      // Phase after this edge
    logic                 reset_seen;      // Reset entry already issued
    logic                 next_reset_seen; // Raised with the reset entry

    // Next values of the output registers
    logic                 next_valid;      // One-cycle jump strobe
    logic [`ADDR_W-1:0]   next_addr;       // Jump target word address
    logic                 next_is_reset;   // Target is the reset entry
    logic [4:0]           next_source;     // Source index of the jump

    // Combinational helpers
    logic                 pick_any;        // Some source pending
    logic [4:0]           pick_index;      // Lowest pending source
    logic [`ADDR_W-1:0]   table_base;      // Base of vector table
    logic [`ADDR_W-1:0]   reset_target;    // Reset entry address

    // Lowest vector number has highest priority
    // A plain scan is enough for 25 sources at this clock; a tree
    // would only pay off for far wider request vectors
    priority_pick #(
        .N (NSRC),
        .W (5)
    ) u_pick (
        .req   (IRQ_PENDING),
        .any   (pick_any),
        .index (pick_index)
    );

    // Address selection: fuse and select bit are independent
    // Both are static settings on the core clock, so no synchroniser;
    // a change only shows in the next jump issued
    always_comb
    begin
        // Zero on the fuse means programmed: reset lands in the boot section
        reset_target = (BOOT_RESET_FUSE == `FUSE_PROGRAMMED) ? BOOT_ADDR : `RESET_OFFSET;
        // Select bit moves the interrupt table only, never the reset entry
        table_base   = VECTOR_TABLE_SELECT_BIT ? BOOT_ADDR : `RESET_OFFSET;
    end

    // Next jump: reset entry once, then interrupts on accept
    // Address, reset flag and source keep their last values unless a jump is issued; the strobe drops back to zero
    always_comb
    begin
        next_state      = state;
        next_reset_seen = reset_seen;
        next_valid      = 1'b0;
        next_addr       = JUMP_ADDR;
        next_is_reset   = JUMP_IS_RESET;
        next_source     = JUMP_SOURCE;
        unique case (state)
            ST_IDLE:
            begin
                if (!reset_seen)
                begin
                    // First cycle out of reset: form the reset entry
                    next_state = ST_RESET;
                end
                else if (IRQ_ACCEPT && pick_any)
                begin
                    // Take; an accept with nothing pending is ignored
                    next_state = ST_IRQ;
                end
                else
                begin
                    // Nothing to do, stay idle
                    next_state = ST_IDLE;
                end
            end
            ST_RESET:
            begin
                // Reset entry issued one cycle
                next_valid      = 1'b1;
                next_addr       = reset_target;
                next_is_reset   = 1'b1;
                next_source     = `NO_SOURCE;
                next_reset_seen = 1'b1;
                next_state      = ST_IDLE;
            end
            ST_IRQ:
            begin
                // Base + first vector + index slots, one word each
                // Pending is looked at again here, not at the accept,
                // so a lower source that rose in between wins
                next_valid    = 1'b1;
                next_addr     = table_base + `FIRST_VECTOR
                              + (`ADDR_W'(pick_index) * `SLOT_WORDS);
                next_is_reset = 1'b0;
                next_source   = pick_index;
                next_state    = ST_IDLE;
            end
            default:
            begin
                // Illegal code: back to idle without a jump
                next_state = ST_IDLE;
            end
        endcase
    end

    // Register everything; outputs come from flops
    // Reset clears reset_seen, so every release issues the entry again
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            // Quiet outputs while reset is held
            state         <= ST_IDLE;
            reset_seen    <= 1'b0;
            JUMP_VALID    <= 1'b0;
            JUMP_ADDR     <= `RESET_OFFSET;
            JUMP_IS_RESET <= 1'b0;
            JUMP_SOURCE   <= `NO_SOURCE;
        end
        else
        begin
            // Phase and outputs advance together
            state         <= next_state;
            reset_seen    <= next_reset_seen;
            JUMP_VALID    <= next_valid;
            JUMP_ADDR     <= next_addr;
            JUMP_IS_RESET <= next_is_reset;
            JUMP_SOURCE   <= next_source;
        end
    end

    // Checks on the jump stream, all on the core clock
    // They watch this block's outputs, its inputs and its sequencer state

    // Reset entry follows the fuse as it stood when the entry was formed
    a_reset_entry_addr: assert property (@(posedge CLK) disable iff (RESET)
        (JUMP_VALID && JUMP_IS_RESET) |->
        (JUMP_ADDR == (($past(BOOT_RESET_FUSE) == `FUSE_PROGRAMMED) ? BOOT_ADDR : `RESET_OFFSET)))
        else $error("Reset entry address wrong");

    // Interrupt target: table base, first vector, one word per source
    // The select bit is taken from the issue cycle, like the design does
    a_irq_vector_addr: assert property (@(posedge CLK) disable iff (RESET)
        (JUMP_VALID && !JUMP_IS_RESET) |->
        (JUMP_ADDR == ($past(VECTOR_TABLE_SELECT_BIT) ? BOOT_ADDR : `RESET_OFFSET)
                      + `FIRST_VECTOR + `ADDR_W'(JUMP_SOURCE)))
        else $error("Interrupt vector address wrong");

    // Reset entry on the second edge after release, never on the first
    a_reset_after_rel: assert property (@(posedge CLK)
        $fell(RESET) |-> !JUMP_VALID ##1 !JUMP_VALID ##1 (JUMP_VALID && JUMP_IS_RESET))
        else $error("Reset entry not issued after release");

    // An accepted interrupt is answered exactly two edges later
    a_accept_to_jump: assert property (@(posedge CLK) disable iff (RESET)
        (state == ST_IDLE && reset_seen && IRQ_ACCEPT && |IRQ_PENDING) |-> ##2 (JUMP_VALID && !JUMP_IS_RESET))
        else $error("Accepted interrupt gave no jump");

    // Nothing pending below the source served, and that source was pending
    a_lowest_first: assert property (@(posedge CLK) disable iff (RESET)
        (state == ST_IRQ) |=> ((($past(IRQ_PENDING) & ~({NSRC{1'b1}} << JUMP_SOURCE)) == '0)
                              && (($past(IRQ_PENDING) & ({{(NSRC-1){1'b0}}, 1'b1} << JUMP_SOURCE)) != '0)))
        else $error("Not the lowest pending source");

    // The strobe never stands for two cycles in a row
    a_valid_one_cycle: assert property (@(posedge CLK) disable iff (RESET)
        JUMP_VALID |=> !JUMP_VALID)
        else $error("Jump valid held too long");

    // Targets in the application table stay inside the vector slots
    a_vec_in_range: assert property (@(posedge CLK) disable iff (RESET)
        (JUMP_VALID && !JUMP_IS_RESET && !$past(VECTOR_TABLE_SELECT_BIT)) |->
        (JUMP_ADDR >= `FIRST_VECTOR && JUMP_ADDR <= `LAST_VECTOR))
        else $error("Vector outside table");

    // Only one reset entry per release of reset
    a_reset_once: assert property (@(posedge CLK) disable iff (RESET)
        (JUMP_VALID && JUMP_IS_RESET) |-> !$past(reset_seen))
        else $error("Reset entry repeated");

    // The reset entry names no interrupt source
    a_reset_no_source: assert property (@(posedge CLK) disable iff (RESET)
        (JUMP_VALID && JUMP_IS_RESET) |-> (JUMP_SOURCE == `NO_SOURCE))
        else $error("Reset entry carries a source");

    // The target only moves together with the strobe
    a_addr_holds: assert property (@(posedge CLK) disable iff (RESET)
        !JUMP_VALID |-> $stable(JUMP_ADDR))
        else $error("Jump address changed without strobe");

    // An accept with nothing pending leaves the sequencer idle
    a_empty_refused: assert property (@(posedge CLK) disable iff (RESET)
        (state == ST_IDLE && reset_seen && !(|IRQ_PENDING)) |=> (state == ST_IDLE))
        else $error("Sequencer left idle with nothing pending");

    // Interrupt jumps name a source that exists
    a_source_legal: assert property (@(posedge CLK) disable iff (RESET)
        (JUMP_VALID && !JUMP_IS_RESET) |-> (JUMP_SOURCE < NSRC))
        else $error("Jump source out of range");
endmodule : reset_irq_vector_locator
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the vector locator
`include "vector_locator_cfg.svh"
`default_nettype none
`define CHK(NM, EXP, GOT) begin n_compared++; if ((GOT) !== (EXP)) begin failures++; \
    $display("[FAIL] %s expected %0h seen %0h", NM, EXP, GOT); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] BOOT = `BOOT_RESET;  // Boot section start
    logic        clk = 1'b0, rst = 1'b1, fuse = 1'b1, sel = 1'b0, en = 1'b0;
    logic [24:0] post = '0;
    logic [24:0] pending;
    logic        accept, valid, is_rst;
    logic [11:0] addr;
    logic [4:0]  src;
    int          failures = 0;
    int          n_compared = 0;
    always #10 clk = ~clk;  // 50 MHz
    reset_irq_vector_locator #(.NSRC(25), .BOOT_ADDR(BOOT)) dut_u (.CLK(clk), .RESET(rst),
        .BOOT_RESET_FUSE(fuse), .VECTOR_TABLE_SELECT_BIT(sel), .IRQ_PENDING(pending),
        .IRQ_ACCEPT(accept), .JUMP_VALID(valid), .JUMP_ADDR(addr), .JUMP_IS_RESET(is_rst),
        .JUMP_SOURCE(src));
    core_irq_model core_u (.clk(clk), .en(en), .post(post), .jv(valid), .jr(is_rst),
        .js(src), .pending(pending), .accept(accept));
    // Verdict and end of run
    task automatic close_out;
        $display("Compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out
    // Bounded wait for the next jump, then check where it lands
    task automatic wait_jump(input logic [11:0] ea, input logic er, input logic [4:0] es);
        @(negedge clk);
        for (int k = 0; k < 20 && valid !== 1'b1; k++)
            @(negedge clk);
        `CHK("valid", 1'b1, valid)
        `CHK("addr", ea, addr)
        `CHK("is_reset", er, is_rst)
        `CHK("source", es, src)
    endtask : wait_jump
    // Reset under one fuse and select setting, expect the reset entry
    task automatic t_reset(input logic f, input logic s);
        @(posedge clk);
        rst <= 1'b1;
        fuse <= f;
        sel <= s;
        en <= 1'b0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        wait_jump((f === 1'b0) ? BOOT : 12'h000, 1'b1, 5'h00);
        @(posedge clk);
        en <= 1'b1;
    endtask : t_reset
    // Each source alone lands on its own slot, one word apart
    task automatic t_each;
        for (int n = 0; n < 25; n++)
        begin
            @(posedge clk);
            post <= 25'h1 << n;
            @(posedge clk);
            post <= '0;
            wait_jump((sel ? BOOT : 12'h000) + 12'h001 + 12'(n), 1'b0, 5'(n));
        end
    endtask : t_each
    // Three flags at once are served lowest vector first
    task automatic t_prio;
        @(posedge clk);
        post <= 25'h1000084;
        @(posedge clk);
        post <= '0;
        wait_jump((sel ? BOOT : 12'h000) + 12'h003, 1'b0, 5'h02);
        wait_jump((sel ? BOOT : 12'h000) + 12'h008, 1'b0, 5'h07);
        wait_jump((sel ? BOOT : 12'h000) + 12'h019, 1'b0, 5'h18);
    endtask : t_prio
    // Accepts with nothing pending are ignored, address holds
    task automatic t_refuse;
        logic [11:0] last;
        last = addr;
        repeat (6)
        begin
            @(negedge clk);
            `CHK("idle valid", 1'b0, valid)
            `CHK("addr hold", last, addr)
        end
    endtask : t_refuse
    // All four fuse and select combinations
    initial
    begin
        for (int i = 0; i < 4; i++)
        begin
            t_reset(i[1], i[0]);
            t_each;
            t_prio;
            t_refuse;
        end
        close_out;
    end
    // Hang guard, well past the expected run of about 510 cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        failures++;
        close_out;
    end
endmodule : tb_top
`default_nettype wire

/* File: vector_locator_cfg.svh */
// Constants for the reset and interrupt vector locator
`ifndef VECTOR_LOCATOR_CFG_SVH
`define VECTOR_LOCATOR_CFG_SVH
`define ADDR_W        12
`define NUM_SRC       25
`define RESET_OFFSET  12'h000
`define FIRST_VECTOR  12'h001
`define LAST_VECTOR   12'h019
`define NO_SOURCE     5'h00
`define SLOT_WORDS    12'h001
`define BOOT_RESET    12'hc00
`define FUSE_PROGRAMMED 1'b0
`endif

/* File: vector_locator_pkg.sv */
// Types shared by the vector locator
`default_nettype none
package vector_locator_pkg;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_RESET = 2'b01,
        ST_IRQ   = 2'b10
    } jump_state_t;
endpackage : vector_locator_pkg
`default_nettype wire
